// ### src/pcl_pkg.sv
// Constants shared by the pin configuration block
package pcl_pkg;
  // Port geometry
  localparam int NUM_PINS = 32;
  localparam int SLOT_W = 3;
  localparam int NUM_SLOTS = 8;
  localparam int WORD_W = 16;
  localparam int IDX_W = 5;
  localparam int PADDR_W = 12;
  // Byte offsets of the first and last pin words
  localparam logic [PADDR_W-1:0] OFS_FIRST = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_LAST = 12'h07c;
  // Field positions inside the lower half of the word
  localparam int SLOT_LSB = 8;
  localparam int SLOT_MSB = 10;
  localparam int BIT_DRIVE = 6;
  localparam int BIT_FILTER = 4;
  localparam int BIT_SLOW = 2;
  localparam int BIT_PULL_ON = 1;
  localparam int BIT_PULL_UP = 0;
  // Slot codes
  localparam logic [SLOT_W-1:0] SLOT_ANALOG = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_GPIO = 3'h1;
  // Bits that can ever hold a one; all others read zero
  localparam logic [WORD_W-1:0] LEGAL_MASK = 16'h0757;
  // Values after reset and default feature support
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [NUM_PINS-1:0] FEAT_ALL = 32'hffffffff;
  localparam logic [NUM_SLOTS-1:0] SLOTS_ALL = 8'hff;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage : pcl_pkg

// ### src/pcl_top.sv
// Pin configuration words (lower half) with APB access and pad control
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Function
// [RULE1] Bits 15-11, 7, 5, 3 read zero
// [RULE2] Slot field 10-8 selects pin use
// [RULE3] Unimplemented slot codes are reserved
// [RULE4] Bit 6 sets high drive on outputs
// [RULE5] Missing features make their bit read-only
// [RULE6] Bit 4 enables input filter when digital
// [RULE7] Bit 2 selects slow edges on outputs
// [RULE8] Bit 1 enables pull on digital input
// [RULE9] Bit 0 chooses pullup, needs pull enable
// [RULE10] Pad settings same in every digital slot
// [RULE11] Analog slot disables all digital functions
// [RULE12] Pull off while output buffer drives
// [RULE13] Per-pin feature support is a parameter
module pcl_top #(
  parameter logic [pcl_pkg::NUM_PINS-1:0] FEAT_DRIVE = pcl_pkg::FEAT_ALL,
  parameter logic [pcl_pkg::NUM_PINS-1:0] FEAT_FILTER = pcl_pkg::FEAT_ALL,
  parameter logic [pcl_pkg::NUM_PINS-1:0] FEAT_SLOW = pcl_pkg::FEAT_ALL,
  parameter logic [pcl_pkg::NUM_PINS-1:0] FEAT_PULL_ON = pcl_pkg::FEAT_ALL,
  parameter logic [pcl_pkg::NUM_PINS-1:0] FEAT_PULL_UP = pcl_pkg::FEAT_ALL,
  parameter logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::NUM_SLOTS-1:0] SLOT_OK =
    {pcl_pkg::NUM_PINS{pcl_pkg::SLOTS_ALL}},
  parameter logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::WORD_W-1:0] RST_CFG =
    {pcl_pkg::NUM_PINS{pcl_pkg::RST_WORD}}
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pcl_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral requests per slot (slot 1 is GPIO)
  input wire logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::NUM_SLOTS-1:0] alt_do,
  input wire logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::NUM_SLOTS-1:0] alt_oe,
  // Pad control
  output logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::SLOT_W-1:0] pad_slot,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_do,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_oe,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_ie,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_drive_hi,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_slow,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_filter,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_pull_on,
  output logic [pcl_pkg::NUM_PINS-1:0] pad_pull_up
);
  import pcl_pkg::*;

  // Word-aligned address inside the pin word range
  function automatic logic addr_ok(input logic [PADDR_W-1:0] a);
    addr_ok = (a >= OFS_FIRST) && (a <= OFS_LAST) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  // Pin index from a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [PADDR_W-1:0] a);
    reg_index = a[IDX_W+1:2];
  endfunction : reg_index

  // Stored configuration words
  logic [NUM_PINS-1:0][WORD_W-1:0] cfg;
  logic setup_phase;
  logic wr_go;

  assign setup_phase = psel && !penable;
  // Write lands at the completing edge of a good access
  assign wr_go = psel && penable && pready && pwrite && addr_ok(paddr);

  // One wait-free access phase: ready rises in the cycle after setup
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Error answer for unmapped or unaligned addresses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase && !addr_ok(paddr);
    end
  end

  // Read data captured in setup; upper half and reserved bits read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= RD_ZERO;
    end else if (setup_phase && !pwrite && addr_ok(paddr)) begin
      prdata <= {16'h0000, cfg[reg_index(paddr)] & LEGAL_MASK}; // [RULE1]
    end else if (setup_phase) begin
      prdata <= RD_ZERO;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      logic [WORD_W-1:0] wmask;
      logic [WORD_W-1:0] next_cfg;
      logic [SLOT_W-1:0] wslot;
      logic dig;
      logic drv;

      // Writable bits: only features this pin supports
      assign wmask = LEGAL_MASK & ~(16'h0007 << SLOT_LSB)
        & ({15'h0000, FEAT_DRIVE[i]} << BIT_DRIVE) // [RULE5] [RULE13]
        | LEGAL_MASK & ({15'h0000, FEAT_FILTER[i]} << BIT_FILTER)
        | LEGAL_MASK & ({15'h0000, FEAT_SLOW[i]} << BIT_SLOW)
        | LEGAL_MASK & ({15'h0000, FEAT_PULL_ON[i]} << BIT_PULL_ON)
        | LEGAL_MASK & ({15'h0000, FEAT_PULL_UP[i]} << BIT_PULL_UP);
      assign wslot = pwdata[SLOT_MSB:SLOT_LSB];

      // Merge written bits; slot codes the pin lacks leave the slot as is
      always_comb begin
        next_cfg = (cfg[i] & ~wmask) | (pwdata[WORD_W-1:0] & wmask); // [RULE5]
        if (SLOT_OK[i][wslot]) begin
          next_cfg[SLOT_MSB:SLOT_LSB] = wslot; // [RULE2] [RULE3]
        end
      end

      // Configuration word storage
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          cfg[i] <= RST_CFG[i] & LEGAL_MASK; // [RULE1] [RULE13]
        end else if (wr_go && reg_index(paddr) == IDX_W'(i)) begin
          cfg[i] <= next_cfg & LEGAL_MASK; // [RULE1] [RULE13]
        end
      end

      // Any non-analog slot is digital; settings ignore which one
      assign dig = cfg[i][SLOT_MSB:SLOT_LSB] != SLOT_ANALOG; // [RULE10] [RULE11]
      assign drv = dig && alt_oe[i][cfg[i][SLOT_MSB:SLOT_LSB]];

      // Slot select and peripheral signal routing to the pad
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pad_slot[i] <= SLOT_ANALOG;
          pad_do[i] <= 1'b0;
          pad_oe[i] <= 1'b0;
          pad_ie[i] <= 1'b0;
        end else begin
          pad_slot[i] <= cfg[i][SLOT_MSB:SLOT_LSB]; // [RULE2]
          pad_do[i] <= dig && alt_do[i][cfg[i][SLOT_MSB:SLOT_LSB]];
          pad_oe[i] <= drv; // [RULE11]
          pad_ie[i] <= dig; // [RULE11]
        end
      end

      // Electrical controls, qualified by the pin's direction except the filter, which needs only a digital slot
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pad_drive_hi[i] <= 1'b0;
          pad_slow[i] <= 1'b0;
          pad_filter[i] <= 1'b0;
          pad_pull_on[i] <= 1'b0;
          pad_pull_up[i] <= 1'b0;
        end else begin
          pad_drive_hi[i] <= drv && cfg[i][BIT_DRIVE]; // [RULE4] [RULE10]
          pad_slow[i] <= drv && cfg[i][BIT_SLOW]; // [RULE7] [RULE10]
          pad_filter[i] <= dig && cfg[i][BIT_FILTER]; // [RULE6] [RULE11]
          pad_pull_on[i] <= dig && !drv && cfg[i][BIT_PULL_ON]; // [RULE8] [RULE12]
          pad_pull_up[i] <= dig && !drv && cfg[i][BIT_PULL_ON]
            && cfg[i][BIT_PULL_UP]; // [RULE9] [RULE12]
        end
      end
    end
  endgenerate
endmodule : pcl_top

// ### testbench/pcl_top_props.sv
// Concurrent checks on the pin configuration block's ports
`timescale 1ns/1ps
module pcl_top_props (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pad control
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pad_ie,
  input wire logic [31:0] pad_drive_hi,
  input wire logic [31:0] pad_slow,
  input wire logic [31:0] pad_filter,
  input wire logic [31:0] pad_pull_on,
  input wire logic [31:0] pad_pull_up
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready pulse wrong");
  property p_resv; pready && !pwrite |-> (prdata & ~32'h00000757) == '0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit read one");
  property p_drv; (pad_drive_hi & ~pad_oe) == '0; endproperty
  a_drv: assert property (p_drv) else $error("drive without output");
  property p_flt; (pad_filter & ~pad_ie) == '0; endproperty
  a_flt: assert property (p_flt) else $error("filter without input");
  property p_slw; (pad_slow & ~pad_oe) == '0; endproperty
  a_slw: assert property (p_slw) else $error("slew without output");
  property p_pup; (pad_pull_up & ~pad_pull_on) == '0; endproperty
  a_pup: assert property (p_pup) else $error("pullup without pull");
  property p_ana; ((pad_oe | pad_pull_on) & ~pad_ie) == '0; endproperty
  a_ana: assert property (p_ana) else $error("digital use in analog");
  property p_pof; (pad_pull_on & pad_oe) == '0; endproperty
  a_pof: assert property (p_pof) else $error("pull on while driving");
endmodule : pcl_top_props
bind pcl_top pcl_top_props pcl_top_props_inst (.*);

// ### testbench/pcl_periph.sv
// Peripheral side model: per-slot data and drive requests for every pin
`timescale 1ns/1ps
module pcl_periph (
  // Requests from the bench
  input wire logic oe_req,
  input wire logic do_val,
  // Per-pin, per-slot peripheral signals
  output logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::NUM_SLOTS-1:0] alt_do,
  output logic [pcl_pkg::NUM_PINS-1:0][pcl_pkg::NUM_SLOTS-1:0] alt_oe
);
  import pcl_pkg::*;
  // Odd slots carry the inverse of even slots, so a wrong selection shows
  assign alt_do = {NUM_PINS{8'haa ^ {NUM_SLOTS{do_val}}}};
  assign alt_oe = {NUM_PINS * NUM_SLOTS{oe_req}};
endmodule : pcl_periph

// ### testbench/pcl_top_bench.sv
// Register and pad checks for the pin configuration block
`timescale 1ns/1ps
module pcl_top_bench;
  import pcl_pkg::*;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, oe_req = 0;
  logic pready, pslverr, err, d, e, p;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [NUM_PINS-1:0][NUM_SLOTS-1:0] alt_do, alt_oe;
  logic [NUM_PINS-1:0][SLOT_W-1:0] pad_slot;
  logic [NUM_PINS-1:0] pad_do, pad_oe, pad_ie, pad_drive_hi, pad_slow, pad_filter;
  logic [NUM_PINS-1:0] pad_pull_on, pad_pull_up;
  int mismatches = 0, num_checks = 0;
  initial forever #10 clk_sys = ~clk_sys;
  pcl_top pcl_top_inst (.*);
  pcl_periph pcl_periph_inst (.oe_req, .do_val(oe_req), .alt_do, .alt_oe);
  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      $display("MISMATCH %s exp %h got %h", n, x, g);
      mismatches++;
    end
  endtask : chk
  // One APB transfer, then an idle cycle
  task automatic xfer(logic w, logic [PADDR_W-1:0] a, logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    // Look at the answer mid-cycle, where it stands settled before the edge
    for (int n = 0; n < 9; n++) begin
      @(negedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      chk("pready", 1, 32'(pready));
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    @(posedge clk_sys);
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask : xfer
  // Reset, the last word, refusals, then every slot with and without drive
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    xfer(0, 12'h07c, 0);
    chk("reset word", 0, rd);
    xfer(1, 12'h07c, 32'hfffff8a8);
    xfer(0, 12'h07c, 0);
    chk("reserved", 0, rd);
    xfer(1, 12'h080, 32'h00000757);
    chk("slverr", 1, 32'(err));
    xfer(0, 12'h00e, 0);
    chk("slverr", 1, 32'(err));
    for (int o = 0; o < 2; o++) begin
      oe_req <= o[0];
      for (int s = 0; s < 8; s++) begin
        xfer(1, 12'h00c, {21'h1fffff, s[2:0], o[0] ? 8'hff : 8'h53});
        xfer(0, 12'h00c, 0);
        chk("word", {21'h0, s[2:0], o[0] ? 8'h57 : 8'h53}, rd);
        d = s != 0;
        e = d & o[0];
        p = d & !e;
        chk("pads", 32'({s[2:0], d, e, d & (s[0] ^ o[0]), e, e, d, p, p}), 32'({pad_slot[3],
          pad_ie[3], pad_oe[3], pad_do[3], pad_drive_hi[3], pad_slow[3], pad_filter[3],
          pad_pull_on[3], pad_pull_up[3]}));
      end
    end
    end_sim();
  end
endmodule : pcl_top_bench
